//--- include/tmcs_conv_if.sv
`timescale 1ns/10ps
interface tmcs_conv_if;
    logic       conv_done;
    logic [2:0] conv_channel;
    logic [7:0] conv_temp;
    logic [7:0] alert_limit;
    logic [7:0] overtemp_limit;
    logic       halt;
    logic       soft_rst;
    logic [7:0] alert_hit;
    logic [1:0] overtemp_level;

    modport bank (output conv_done, conv_channel, conv_temp, alert_limit,
                  overtemp_limit, halt, soft_rst,
                  input alert_hit, overtemp_level);
    modport eval (input conv_done, conv_channel, conv_temp, alert_limit,
                  overtemp_limit, halt, soft_rst,
                  output alert_hit, overtemp_level);
endinterface

//--- include/tmcs_pkg.sv
// What this block does
// R01 - Standby bit seven of control_one halts conversions until cleared.
// R02 - Soft reset bit six restores power-on values, then clears itself.
// R03 - Bus timeout active while bit five is zero, off while one.
// R04 - Bit four makes the sequencer convert remote channel one more often.
// R05 - Bit three applies resistance cancellation to remote channel one only.
// R06 - alarm_mask bit six keeps local high-limit off the alarm output.
// R07 - alarm_mask bits zero to three mask remote channels one to four.
// R08 - overtemp_mask bits zero and three block remote one and four overtemp.
// R09 - Flag bit six sets when local temperature exceeds its high limit.
// R10 - Flag bits zero to three set when remotes exceed their limits.
// R11 - All defined control, mask and flag bits read zero after reset.
// R12 - Reading high_limit_flags clears them; they set again next conversion.
// R13 - Alarm output rises on newly set unmasked flags, drops on flag read or response.
// R14 - Overtemp output holds until temperature falls below limit minus four.
// R15 - Reserved bits read zero and ignore writes.
package tmcs_pkg;
    localparam logic [7:0] ADDR_CONTROL_ONE      = 8'h41;
    localparam logic [7:0] ADDR_ALARM_MASK       = 8'h42;
    localparam logic [7:0] ADDR_OVERTEMP_MASK    = 8'h43;
    localparam logic [7:0] ADDR_HIGH_LIMIT_FLAGS = 8'h44;

    localparam logic [7:0] RESET_VALUE           = 8'h00;
    localparam logic [7:0] CONTROL_ONE_USED      = 8'hf8;
    localparam logic [7:0] ALARM_MASK_USED       = 8'h4f;
    localparam logic [7:0] OVERTEMP_MASK_USED    = 8'h09;
    localparam logic [7:0] FLAGS_USED            = 8'h4f;

    localparam int         BIT_STANDBY           = 7;
    localparam int         BIT_SOFT_RESET        = 6;
    localparam int         BIT_TIMEOUT_OFF       = 5;
    localparam int         BIT_FAST_REMOTE1      = 4;
    localparam int         BIT_RES_CANCEL        = 3;
    localparam int         BIT_FLAG_LOCAL        = 6;
    localparam int         BIT_REMOTE1_OT        = 0;
    localparam int         BIT_REMOTE4_OT        = 3;

    localparam logic [2:0] CHAN_LOCAL            = 3'h0;
    localparam logic [2:0] CHAN_REMOTE1          = 3'h1;
    localparam logic [2:0] CHAN_REMOTE4          = 3'h4;
    localparam logic [8:0] HYSTERESIS_DEGREES    = 9'h004;
endpackage

//--- logic/tmcs_bank.sv
`timescale 1ns/10ps
module tmcs_bank (
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_rd_in,
    input  wire logic       alert_response_in,
    input  wire logic       conv_done_in,
    input  wire logic [2:0] conv_channel_in,
    input  wire logic [7:0] conv_temp_in,
    input  wire logic [7:0] alert_limit_in,
    input  wire logic [7:0] overtemp_limit_in,
    output logic      [7:0] reg_rdata_out,
    output logic            standby_out,
    output logic            soft_reset_out,
    output logic            smbus_timeout_en_out,
    output logic            fast_remote1_out,
    output logic            res_cancel_out,
    output logic            alert_out,
    output logic            overtemp_shutdown_output_out
);
    tmcs_conv_if conv ();

    logic       standby;
    logic       next_standby;
    logic       timeout_en;
    logic       next_timeout_en;
    logic       fast_remote1;
    logic       next_fast_remote1;
    logic       res_cancel;
    logic       next_res_cancel;
    logic       soft_reset;
    logic       next_soft_reset;
    logic [7:0] alarm_mask;
    logic [7:0] next_alarm_mask;
    logic [7:0] overtemp_mask;
    logic [7:0] next_overtemp_mask;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic       alert;
    logic       next_alert;
    logic       overtemp;
    logic       next_overtemp;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic [7:0] control_one_view;
    logic       flags_read;
    logic       soft_req;
    logic [7:0] unmasked_hit;

    // Strobe decode lives here so the command byte map sits in one place
    function automatic logic addr_is(input logic [7:0] addr,
                                     input logic [7:0] target);
        addr_is = (addr == target);
    endfunction

    // Reserved bits are dropped on every store, so they always read zero
    function automatic logic [7:0] keep_used(input logic [7:0] value,
                                             input logic [7:0] used);
        keep_used = value & used;
    endfunction

    tmcs_eval u_eval (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .conv     (conv)
    );

    // Results come from logic on this clock, so no synchroniser
    assign conv.conv_done      = conv_done_in;
    assign conv.conv_channel   = conv_channel_in;
    assign conv.conv_temp      = conv_temp_in;
    assign conv.alert_limit    = alert_limit_in;
    assign conv.overtemp_limit = overtemp_limit_in;
    assign conv.halt           = standby; // R01
    assign conv.soft_rst       = soft_reset; // R02

    // Soft reset bit is left out of the read view, so it always reads zero
    always_comb begin
        control_one_view = 8'h00;
        control_one_view[tmcs_pkg::BIT_STANDBY]      = standby;
        control_one_view[tmcs_pkg::BIT_TIMEOUT_OFF]  = ~timeout_en;
        control_one_view[tmcs_pkg::BIT_FAST_REMOTE1] = fast_remote1;
        control_one_view[tmcs_pkg::BIT_RES_CANCEL]   = res_cancel;
    end

    assign flags_read = reg_rd_in
                        && addr_is(reg_addr_in,
                                   tmcs_pkg::ADDR_HIGH_LIMIT_FLAGS);
    assign soft_req   = reg_wr_in
                        && addr_is(reg_addr_in, tmcs_pkg::ADDR_CONTROL_ONE)
                        && reg_wdata_in[tmcs_pkg::BIT_SOFT_RESET];
    assign unmasked_hit = conv.alert_hit & ~alarm_mask; // R06 R07

    always_comb begin
        next_standby       = standby;
        next_timeout_en    = timeout_en;
        next_fast_remote1  = fast_remote1;
        next_res_cancel    = res_cancel;
        next_alarm_mask    = alarm_mask;
        next_overtemp_mask = overtemp_mask;
        next_soft_reset    = soft_req; // R02
        next_rdata         = rdata;
        if (reg_wr_in && !soft_req) begin
            case (reg_addr_in)
                tmcs_pkg::ADDR_CONTROL_ONE: begin
                    next_standby      = reg_wdata_in[tmcs_pkg::BIT_STANDBY];
                    next_timeout_en   =
                        ~reg_wdata_in[tmcs_pkg::BIT_TIMEOUT_OFF]; // R03
                    next_fast_remote1 =
                        reg_wdata_in[tmcs_pkg::BIT_FAST_REMOTE1]; // R04
                    next_res_cancel   =
                        reg_wdata_in[tmcs_pkg::BIT_RES_CANCEL]; // R05
                end
                tmcs_pkg::ADDR_ALARM_MASK: begin
                    next_alarm_mask = keep_used(reg_wdata_in,
                        tmcs_pkg::ALARM_MASK_USED); // R15
                end
                tmcs_pkg::ADDR_OVERTEMP_MASK: begin
                    next_overtemp_mask = keep_used(reg_wdata_in,
                        tmcs_pkg::OVERTEMP_MASK_USED); // R15
                end
                default: begin
                end
            endcase
        end
        // Read data is held until the next read, so a slow host sees it
        if (reg_rd_in) begin
            case (reg_addr_in)
                tmcs_pkg::ADDR_CONTROL_ONE:      next_rdata = control_one_view;
                tmcs_pkg::ADDR_ALARM_MASK:       next_rdata = alarm_mask;
                tmcs_pkg::ADDR_OVERTEMP_MASK:    next_rdata = overtemp_mask;
                tmcs_pkg::ADDR_HIGH_LIMIT_FLAGS: next_rdata = flags;
                default:                         next_rdata = 8'h00;
            endcase
        end
        // The host asked for power-on state, so nothing else it wrote counts
        if (soft_req) begin
            next_standby       = 1'b0; // R02
            next_timeout_en    = 1'b1;
            next_fast_remote1  = 1'b0;
            next_res_cancel    = 1'b0;
            next_alarm_mask    = tmcs_pkg::RESET_VALUE;
            next_overtemp_mask = tmcs_pkg::RESET_VALUE;
        end
    end

    always_comb begin
        next_flags = flags;
        if (flags_read) begin
            next_flags = 8'h00; // R12
        end
        // A hit in the clearing cycle wins over the read
        next_flags = keep_used(next_flags | conv.alert_hit,
                               tmcs_pkg::FLAGS_USED); // R09 R10
        next_alert = alert;
        if (flags_read || alert_response_in) begin
            next_alert = 1'b0; // R13
        end
        // Unmasking old flags never raises the alert; only a fresh hit does
        next_alert = (next_alert || (|unmasked_hit))
                     && (|(next_flags & ~alarm_mask)); // R13
        next_overtemp =
            (conv.overtemp_level[0]
             && !overtemp_mask[tmcs_pkg::BIT_REMOTE1_OT])
            || (conv.overtemp_level[1]
                && !overtemp_mask[tmcs_pkg::BIT_REMOTE4_OT]); // R08 R14
        if (soft_reset) begin
            next_flags    = tmcs_pkg::RESET_VALUE; // R02
            next_alert    = 1'b0;
            next_overtemp = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            standby       <= 1'b0; // R11
            timeout_en    <= 1'b1;
            fast_remote1  <= 1'b0;
            res_cancel    <= 1'b0;
            soft_reset    <= 1'b0;
            alarm_mask    <= tmcs_pkg::RESET_VALUE;
            overtemp_mask <= tmcs_pkg::RESET_VALUE;
            rdata         <= 8'h00;
        end else begin
            standby       <= next_standby;
            timeout_en    <= next_timeout_en;
            fast_remote1  <= next_fast_remote1;
            res_cancel    <= next_res_cancel;
            soft_reset    <= next_soft_reset;
            alarm_mask    <= next_alarm_mask;
            overtemp_mask <= next_overtemp_mask;
            rdata         <= next_rdata;
        end
    end

    // Status clears one edge after the controls, on the soft reset pulse
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flags    <= tmcs_pkg::RESET_VALUE; // R11
            alert    <= 1'b0;
            overtemp <= 1'b0;
        end else begin
            flags    <= next_flags;
            alert    <= next_alert;
            overtemp <= next_overtemp;
        end
    end

    assign reg_rdata_out                = rdata;
    assign standby_out                  = standby;
    assign soft_reset_out               = soft_reset;
    assign smbus_timeout_en_out         = timeout_en;
    assign fast_remote1_out             = fast_remote1;
    assign res_cancel_out               = res_cancel;
    assign alert_out                    = alert;
    assign overtemp_shutdown_output_out = overtemp;
endmodule

//--- logic/tmcs_eval.sv
`timescale 1ns/10ps
module tmcs_eval (
    input  wire logic clock_in,
    input  wire logic rstn_in,
    tmcs_conv_if.eval conv
);
    logic [7:0] alert_hit;
    logic [7:0] next_alert_hit;
    logic [1:0] ot_level;
    logic [1:0] next_ot_level;

    // Temperatures and limits are two's complement degrees
    function automatic logic exceeds(input logic [7:0] temp,
                                     input logic [7:0] limit);
        exceeds = $signed(temp) > $signed(limit);
    endfunction

    function automatic logic below_hyst(input logic [7:0] temp,
                                        input logic [7:0] limit);
        logic signed [8:0] floor_v;
        floor_v = $signed({limit[7], limit})
                  - $signed(tmcs_pkg::HYSTERESIS_DEGREES);
        below_hyst = $signed({temp[7], temp}) < floor_v;
    endfunction

    always_comb begin
        next_alert_hit = 8'h00;
        next_ot_level  = ot_level;
        // A conversion landing during standby is ignored
        if (conv.conv_done && !conv.halt) begin // R01
            if (exceeds(conv.conv_temp, conv.alert_limit)) begin
                if (conv.conv_channel == tmcs_pkg::CHAN_LOCAL) begin
                    next_alert_hit[tmcs_pkg::BIT_FLAG_LOCAL] = 1'b1; // R09
                end else if (conv.conv_channel <= tmcs_pkg::CHAN_REMOTE4) begin
                    next_alert_hit[conv.conv_channel - 3'h1] = 1'b1; // R10
                end
            end
            if (conv.conv_channel == tmcs_pkg::CHAN_REMOTE1) begin
                if (exceeds(conv.conv_temp, conv.overtemp_limit)) begin
                    next_ot_level[0] = 1'b1;
                end else if (below_hyst(conv.conv_temp,
                                        conv.overtemp_limit)) begin
                    next_ot_level[0] = 1'b0; // R14
                end
            end
            if (conv.conv_channel == tmcs_pkg::CHAN_REMOTE4) begin
                if (exceeds(conv.conv_temp, conv.overtemp_limit)) begin
                    next_ot_level[1] = 1'b1;
                end else if (below_hyst(conv.conv_temp,
                                        conv.overtemp_limit)) begin
                    next_ot_level[1] = 1'b0; // R14
                end
            end
        end
        if (conv.soft_rst) begin
            next_alert_hit = 8'h00; // R02
            next_ot_level  = 2'h0;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            alert_hit <= 8'h00;
            ot_level  <= 2'h0;
        end else begin
            alert_hit <= next_alert_hit;
            ot_level  <= next_ot_level;
        end
    end

    assign conv.alert_hit      = alert_hit;
    assign conv.overtemp_level = ot_level;
endmodule

//--- tb/test_thermal_monitor_config_status.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module test_thermal_monitor_config_status;
    logic       clock_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d, e_v;
    logic       reg_wr_in, reg_rd_in, rd_q = 1'b0;
    logic       alert_response_in = 1'b0;
    logic       conv_done_in = 1'b0;
    logic [2:0] conv_channel_in = 3'h0;
    logic [7:0] conv_temp_in = 8'h00;
    logic [7:0] alert_limit_in = 8'h4f;
    logic [7:0] overtemp_limit_in = 8'h5f;
    logic       standby_out, soft_reset_out, smbus_timeout_en_out;
    logic       fast_remote1_out, res_cancel_out, alert_out;
    logic       overtemp_shutdown_output_out;
    logic [7:0] exp_q[$];
    int         num_errors = 0, samples_checked = 0, cyc = 0, i, j, b;
    int         seed = 32'h5c243d10;

    always #10 clock_in = ~clock_in;
    tmcs_host_model host (.clock_in(clock_in), .reg_addr_out(reg_addr_in),
        .reg_wr_out(reg_wr_in), .reg_wdata_out(reg_wdata_in),
        .reg_rd_out(reg_rd_in));
    tmcs_bank DUT (
        .clock_in                     (clock_in),
        .rstn_in                      (rstn_in),
        .reg_addr_in                  (reg_addr_in),
        .reg_wr_in                    (reg_wr_in),
        .reg_wdata_in                 (reg_wdata_in),
        .reg_rd_in                    (reg_rd_in),
        .alert_response_in            (alert_response_in),
        .conv_done_in                 (conv_done_in),
        .conv_channel_in              (conv_channel_in),
        .conv_temp_in                 (conv_temp_in),
        .alert_limit_in               (alert_limit_in),
        .overtemp_limit_in            (overtemp_limit_in),
        .reg_rdata_out                (reg_rdata_out),
        .standby_out                  (standby_out),
        .soft_reset_out               (soft_reset_out),
        .smbus_timeout_en_out         (smbus_timeout_en_out),
        .fast_remote1_out             (fast_remote1_out),
        .res_cancel_out               (res_cancel_out),
        .alert_out                    (alert_out),
        .overtemp_shutdown_output_out (overtemp_shutdown_output_out)
    );

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    // Outputs follow a result two edges later; the two extra edges are slack
    task automatic conv(input logic [2:0] c, input logic [7:0] t);
        @(posedge clock_in);
        conv_done_in <= 1'b1;
        conv_channel_in <= c;
        conv_temp_in <= t;
        @(posedge clock_in);
        conv_done_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
    endtask

    always @(posedge clock_in) begin
        cyc++;
        if (rd_q && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            `CHK("rdata", e_v, reg_rdata_out)
        end
        rd_q <= reg_rd_in;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        #1;
        `CHK("timeout_en", 1'b1, smbus_timeout_en_out)
        `CHK("alert", 1'b0, alert_out)
        for (i = 0; i < 5; i++) rd_exp(8'h41 + i[7:0], 8'h00);
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            host.wr(8'h41, d & 8'hbf);
            #1;
            `CHK("standby", d[7], standby_out)
            `CHK("timeout_en", ~d[5], smbus_timeout_en_out)
            `CHK("fast", d[4], fast_remote1_out)
            `CHK("cancel", d[3], res_cancel_out)
            rd_exp(8'h41, d & 8'hb8);
            for (j = 0; j < 2; j++) begin
                d = 8'($random(seed));
                host.wr(8'h42 + j[7:0], d);
                rd_exp(8'h42 + j[7:0], d & (j ? 8'h09 : 8'h4f));
            end
        end
        for (i = 0; i < 3; i++) host.wr(8'h41 + i[7:0], 8'h00);
        for (i = 0; i < 5; i++) begin
            b = (i == 0) ? 6 : i - 1;
            conv(i[2:0], 8'h4f);
            conv(i[2:0], 8'hf0);
            rd_exp(8'h44, 8'h00);
            for (j = 0; j < 2; j++) begin
                host.wr(8'h42, j ? 8'(8'h01 << b) : 8'h00);
                conv(i[2:0], 8'h50);
                `CHK("alert", ~j[0], alert_out)
                rd_exp(8'h44, 8'(8'h01 << b));
                #1;
                `CHK("alert", 1'b0, alert_out)
            end
            rd_exp(8'h44, 8'h00);
        end
        host.wr(8'h41, 8'h80);
        conv(3'h0, 8'h50);
        rd_exp(8'h44, 8'h00);
        host.wr(8'h41, 8'h00);
        conv(3'h5, 8'h50);
        conv(3'h1, 8'h50);
        `CHK("alert", 1'b1, alert_out)
        @(posedge clock_in);
        alert_response_in <= 1'b1;
        @(posedge clock_in);
        alert_response_in <= 1'b0;
        #1;
        `CHK("alert", 1'b0, alert_out)
        rd_exp(8'h44, 8'h01);
        for (i = 0; i < 2; i++) begin
            b = i ? 4 : 1;
            conv(b[2:0], 8'h60);
            `CHK("overtemp", 1'b1, overtemp_shutdown_output_out)
            conv(b[2:0], 8'h5b);
            `CHK("overtemp", 1'b1, overtemp_shutdown_output_out)
            conv(b[2:0], 8'h5a);
            `CHK("overtemp", 1'b0, overtemp_shutdown_output_out)
            host.wr(8'h43, i ? 8'h08 : 8'h01);
            conv(b[2:0], 8'h60);
            `CHK("overtemp", 1'b0, overtemp_shutdown_output_out)
            conv(b[2:0], 8'h5a);
            host.wr(8'h43, 8'h00);
        end
        host.wr(8'h42, 8'h4f);
        host.wr(8'h41, 8'hd8);
        #1;
        `CHK("soft_reset", 1'b1, soft_reset_out)
        rd_exp(8'h41, 8'h00);
        rd_exp(8'h42, 8'h00);
        rd_exp(8'h44, 8'h00);
        #1;
        `CHK("standby", 1'b0, standby_out)
        repeat (3) @(posedge clock_in);
        summarize();
    end
endmodule

//--- tb/tmcs_bank_monitor.sv
`timescale 1ns/10ps
module tmcs_bank_monitor (
    input wire logic       clock_in,
    input wire logic       rstn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_rd_in,
    input wire logic       alert_response_in,
    input wire logic       conv_done_in,
    input wire logic [2:0] conv_channel_in,
    input wire logic [7:0] conv_temp_in,
    input wire logic [7:0] alert_limit_in,
    input wire logic [7:0] overtemp_limit_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       standby_out,
    input wire logic       soft_reset_out,
    input wire logic       smbus_timeout_en_out,
    input wire logic       fast_remote1_out,
    input wire logic       res_cancel_out,
    input wire logic       alert_out,
    input wire logic       overtemp_shutdown_output_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    wire cfg    = reg_wr_in && reg_addr_in == 8'h41 && !reg_wdata_in[6];
    wire rst_wr = reg_wr_in && reg_addr_in == 8'h41 && reg_wdata_in[6];
    wire rd_bad = reg_rd_in && (reg_addr_in < 8'h41 || reg_addr_in > 8'h44);

    property p_soft_pulse;
        rst_wr |=> soft_reset_out;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse)
        else $error("no soft reset");
    property p_soft_once;
        soft_reset_out |=> !soft_reset_out;
    endproperty
    a_soft_once: assert property (p_soft_once)
        else $error("reset stuck");
    property p_standby;
        cfg |=> standby_out == $past(reg_wdata_in[7]);
    endproperty
    a_standby: assert property (p_standby)
        else $error("bad standby");
    property p_timeout;
        cfg |=> smbus_timeout_en_out != $past(reg_wdata_in[5]);
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("bad timeout");
    property p_fast;
        cfg |=> fast_remote1_out == $past(reg_wdata_in[4]);
    endproperty
    a_fast: assert property (p_fast)
        else $error("bad fast");
    property p_cancel;
        cfg |=> res_cancel_out == $past(reg_wdata_in[3]);
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("bad cancel");
    property p_unmapped;
        rd_bad |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped data");
    property p_flag_rsvd;
        reg_rd_in && reg_addr_in == 8'h44
            |=> (reg_rdata_out & 8'hb0) == 8'h00;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd)
        else $error("flag bits");
    property p_alert_resp;
        alert_response_in && !$past(conv_done_in) |=> !alert_out;
    endproperty
    a_alert_resp: assert property (p_alert_resp)
        else $error("alert kept");
    // A result takes one edge into the evaluator and one more to the pin
    property p_alert_rise;
        $rose(alert_out) |-> $past(conv_done_in, 2);
    endproperty
    a_alert_rise: assert property (p_alert_rise)
        else $error("alert rise");
    property p_ot_rise;
        $rose(overtemp_shutdown_output_out) |-> $past(conv_done_in, 2);
    endproperty
    a_ot_rise: assert property (p_ot_rise)
        else $error("overtemp rise");
endmodule
bind tmcs_bank tmcs_bank_monitor u_mon (
    .clock_in                     (clock_in),
    .rstn_in                      (rstn_in),
    .reg_addr_in                  (reg_addr_in),
    .reg_wr_in                    (reg_wr_in),
    .reg_wdata_in                 (reg_wdata_in),
    .reg_rd_in                    (reg_rd_in),
    .alert_response_in            (alert_response_in),
    .conv_done_in                 (conv_done_in),
    .conv_channel_in              (conv_channel_in),
    .conv_temp_in                 (conv_temp_in),
    .alert_limit_in               (alert_limit_in),
    .overtemp_limit_in            (overtemp_limit_in),
    .reg_rdata_out                (reg_rdata_out),
    .standby_out                  (standby_out),
    .soft_reset_out               (soft_reset_out),
    .smbus_timeout_en_out         (smbus_timeout_en_out),
    .fast_remote1_out             (fast_remote1_out),
    .res_cancel_out               (res_cancel_out),
    .alert_out                    (alert_out),
    .overtemp_shutdown_output_out (overtemp_shutdown_output_out)
);

//--- tb/tmcs_host_model.sv
`timescale 1ns/10ps
module tmcs_host_model (
    input  wire logic       clock_in,
    output logic      [7:0] reg_addr_out,
    output logic            reg_wr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_rd_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end
    // Released bytes flip so a stale value is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clock_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clock_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
    endtask
endmodule
